// File: tpr_pkg.sv
package tpr_pkg;

    // Clock and guard timing
    localparam int CLK_FREQ_HZ     = 100_000_000;
    localparam int HZ_PER_MHZ      = 1_000_000;
    localparam int GUARD_UNIT_US   = 1;
    localparam int GUARD_UNIT_CYC  = (CLK_FREQ_HZ / HZ_PER_MHZ) * GUARD_UNIT_US;

    // Register indices; byte address is four times the index
    localparam logic [13:0] IDX_GUARD_TIME     = 14'h009f;
    localparam logic [13:0] IDX_MODE_ENABLES   = 14'h068e;
    localparam logic [13:0] IDX_TARGET_CURRENT = 14'h068f;
    localparam logic [13:0] IDX_LOAD_HYST      = 14'h0691;
    localparam logic [13:0] IDX_UNLOAD_HYST    = 14'h0694;
    localparam logic [13:0] IDX_LOW_LIMIT      = 14'h0695;
    localparam logic [13:0] IDX_DRV_STRENGTH   = 14'h0696;
    localparam logic [13:0] IDX_LIMIT_METHOD   = 14'h0697;
    localparam logic [13:0] IDX_INIT_DRIVER    = 14'h0698;
    localparam logic [13:0] IDX_MAX_DROPOUT    = 14'h0699;
    localparam logic [13:0] IDX_WAIT_REG_EN    = 14'h06a0;
    localparam logic [13:0] IDX_POST_RX_EN     = 14'h06a1;
    localparam logic [13:0] IDX_STATUS         = 14'h06a8;

    // Field positions
    localparam int MODE_READER_BIT   = 0;
    localparam int MODE_ACT_INIT_BIT = 1;
    localparam int MODE_ACT_TGT_BIT  = 2;
    localparam int STAT_STATE_LSB    = 0;
    localparam int STAT_RES_LSB      = 16;

    // Codes
    localparam logic [7:0] CODE_ENABLED = 8'h01;
    localparam logic [7:0] METHOD_RON   = 8'h01;
    localparam logic [7:0] METHOD_PWM   = 8'h02;
    localparam logic [1:0] MODE_READER   = 2'h0;
    localparam logic [1:0] MODE_ACT_INIT = 2'h1;
    localparam logic [1:0] MODE_ACT_TGT  = 2'h2;

    // Driver resistance in milliohm
    localparam int         RES_NUM_MOHM      = 10000;
    localparam logic [15:0] RES_MIN_MOHM     = 16'h01f4;
    localparam logic [7:0] STRENGTH_LIMIT    = 8'h14;
    localparam int         TARGET_CEIL_MA    = 350;

    // Reset values
    localparam logic [7:0]  RST_GUARD_TIME   = 8'h0a;
    localparam logic [7:0]  RST_MODE_ENABLES = 8'h07;
    localparam logic [15:0] RST_TARGET       = 16'h00fa;
    localparam logic [7:0]  RST_LOAD_HYST    = 8'h0a;
    localparam logic [7:0]  RST_UNLOAD_HYST  = 8'h0a;
    localparam logic [7:0]  RST_LOW_LIMIT    = 8'h00;
    localparam logic [7:0]  RST_STRENGTH     = 8'h14;
    localparam logic [7:0]  RST_METHOD       = 8'h00;
    localparam logic [7:0]  RST_INIT_DRIVER  = 8'h00;
    localparam logic [15:0] RST_MAX_DROPOUT  = 16'h0e10;
    localparam logic [7:0]  RST_WAIT_REG_EN  = 8'h01;
    localparam logic [7:0]  RST_POST_RX_EN   = 8'h01;

    // Bus responses
    localparam logic [1:0] RESP_OKAY   = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    typedef enum logic [2:0] {
        ST_IDLE     = 3'b000,
        ST_PRE_REG  = 3'b001,
        ST_TX_GUARD = 3'b011,
        ST_RX_GUARD = 3'b010,
        ST_POST_REG = 3'b110
    } tpr_state_type;

endpackage

// File: tpr_us_tick.sv
`timescale 1ns/1ps
`default_nettype none
module tpr_us_tick #(
    parameter int CYCLES = 100
) (
    input  wire logic clk_i,
    input  wire logic sys_rst_i,
    input  wire logic clr_i,
    output logic      tick_o
);
    localparam int CW = $clog2(CYCLES + 1);
    localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

    logic [CW-1:0] cnt;

    // Restart on clear so a guard interval is a whole number of units
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            cnt    <= '0;
            tick_o <= 1'b0;
        end else if (clr_i) begin
            cnt    <= '0;
            tick_o <= 1'b0;
        end else if (cnt == LAST) begin
            cnt    <= '0;
            tick_o <= 1'b1;
        end else begin
            cnt    <= cnt + CW'(1);
            tick_o <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// File: tpr_hyst_cmp.sv
`timescale 1ns/1ps
`default_nettype none
module tpr_hyst_cmp (
    input  wire logic [15:0] current_i,
    input  wire logic [15:0] target_i,
    input  wire logic [7:0]  reduction_i,
    input  wire logic [7:0]  load_hyst_i,
    input  wire logic [7:0]  unload_hyst_i,
    output logic             over_o,
    output logic             under_o
);
    logic [16:0] eff_target;

    always_comb begin
        // Lookup table reduction lowers the target, saturating at zero
        if (target_i > {8'h00, reduction_i}) begin
            eff_target = {1'b0, target_i} - {9'h000, reduction_i};
        end else begin
            eff_target = '0;
        end
        over_o  = {1'b0, current_i} > eff_target + {9'h000, load_hyst_i};
        under_o = {1'b0, current_i} + {9'h000, unload_hyst_i} < eff_target;
    end
endmodule
`default_nettype wire

// File: tpr_regulation.sv
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - Per-mode regulation enable bits zero to two
// - Sixteen-bit target current sets current limit
// - Lookup reduction may lower target further
// - Lower supply when current exceeds target plus load
// - Raise supply when current below target minus unload
// - Loading hysteresis is eight-bit absolute deviation
// - Unloading hysteresis is separate eight-bit deviation
// - Hold eight-bit supply low limit for resistance
// - Driver resistance from strength, floor half ohm
// - Low-limit method: off, resistance, pulse width
// - Initial driver value applied at field on
// - Dropout check at field on: safe or stop
// - Dropout limit in millivolts, reset 3600
// - Eight-bit guard time in microseconds
// - One pass before transmit, one after receive
// - Guard time between pass and transmit start
// - Guard time between receive stop and pass
// - Transmit guard always applied regardless of enables
// - Wait interval regulation enabled by code one
// - Post-receive guard and pass enabled by one
module tpr_regulation
    import tpr_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        sys_rst_i,
    input  wire logic [15:0] s_axi_awaddr_i,
    input  wire logic        s_axi_awvalid_i,
    output logic             s_axi_awready_o,
    input  wire logic [31:0] s_axi_wdata_i,
    input  wire logic [3:0]  s_axi_wstrb_i,
    input  wire logic        s_axi_wvalid_i,
    output logic             s_axi_wready_o,
    output logic [1:0]       s_axi_bresp_o,
    output logic             s_axi_bvalid_o,
    input  wire logic        s_axi_bready_i,
    input  wire logic [15:0] s_axi_araddr_i,
    input  wire logic        s_axi_arvalid_i,
    output logic             s_axi_arready_o,
    output logic [31:0]      s_axi_rdata_o,
    output logic [1:0]       s_axi_rresp_o,
    output logic             s_axi_rvalid_o,
    input  wire logic        s_axi_rready_i,
    input  wire logic [1:0]  mode_i,
    input  wire logic [15:0] measured_current_i,
    input  wire logic [7:0]  current_reduction_i,
    input  wire logic [15:0] dropout_mv_i,
    input  wire logic        boost_bypass_i,
    input  wire logic        field_on_i,
    input  wire logic        tx_request_i,
    input  wire logic        rx_stop_i,
    input  wire logic        in_wait_interval_i,
    output logic             supply_down_o,
    output logic             supply_up_o,
    output logic             supply_safe_o,
    output logic             supply_stop_o,
    output logic             tx_start_o,
    output logic             regulating_o,
    output logic [7:0]       driver_strength_code_o,
    output logic [15:0]      driver_res_mohm_o,
    output logic [7:0]       driver_gate_setting_o,
    output logic [7:0]       supply_low_limit_value_o,
    output logic             ron_control_o,
    output logic             pwm_control_o
);
    logic [7:0]    guard_time;
    logic [7:0]    mode_enables;
    logic [15:0]   target_current;
    logic [7:0]    loading_hyst;
    logic [7:0]    unloading_hyst;
    logic [7:0]    low_limit;
    logic [7:0]    method;
    logic [7:0]    initial_driver_value;
    logic [15:0]   max_dropout;
    logic [7:0]    wait_code;
    logic [7:0]    post_code;
    logic          aw_held;
    logic          w_held;
    logic [13:0]   aw_idx;
    logic [31:0]   w_data;
    logic [3:0]    w_strb;
    logic          do_write;
    logic          wr_hit;
    logic          rd_hit;
    logic [31:0]   rd_word;
    logic [13:0]   ar_idx;
    tpr_state_type state;
    tpr_state_type next_state;
    logic [7:0]    guard_cnt;
    logic          load_guard;
    logic          us_tick;
    logic          over;
    logic          under;
    logic          mode_en;
    logic          wait_en;
    logic          post_en;
    logic          regulate_now;

    assign ar_idx   = s_axi_araddr_i[15:2];
    assign do_write = aw_held && w_held;

    // Write channel: address and data taken in either order
    assign s_axi_awready_o = !aw_held && !s_axi_bvalid_o;
    assign s_axi_wready_o  = !w_held && !s_axi_bvalid_o;
    assign s_axi_arready_o = !s_axi_rvalid_o;

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            aw_held <= 1'b0;
            w_held  <= 1'b0;
            aw_idx  <= '0;
            w_data  <= '0;
            w_strb  <= '0;
        end else if (do_write) begin
            aw_held <= 1'b0;
            w_held  <= 1'b0;
        end else begin
            if (s_axi_awvalid_i && s_axi_awready_o) begin
                aw_held <= 1'b1;
                aw_idx  <= s_axi_awaddr_i[15:2];
            end
            if (s_axi_wvalid_i && s_axi_wready_o) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata_i;
                w_strb <= s_axi_wstrb_i;
            end
        end
    end

    always_comb begin
        case (aw_idx)
            IDX_GUARD_TIME, IDX_MODE_ENABLES, IDX_TARGET_CURRENT, IDX_LOAD_HYST,
            IDX_UNLOAD_HYST, IDX_LOW_LIMIT, IDX_DRV_STRENGTH, IDX_LIMIT_METHOD,
            IDX_INIT_DRIVER, IDX_MAX_DROPOUT, IDX_WAIT_REG_EN, IDX_POST_RX_EN,
            IDX_STATUS: wr_hit = 1'b1;
            default: wr_hit = 1'b0;
        endcase
    end

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            s_axi_bvalid_o <= 1'b0;
            s_axi_bresp_o  <= RESP_OKAY;
        end else if (do_write) begin
            s_axi_bvalid_o <= 1'b1;
            s_axi_bresp_o  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready_i) begin
            s_axi_bvalid_o <= 1'b0;
        end
    end

    // Configuration registers
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            guard_time           <= RST_GUARD_TIME;
            mode_enables         <= RST_MODE_ENABLES;
            target_current       <= RST_TARGET;
            loading_hyst         <= RST_LOAD_HYST;
            unloading_hyst       <= RST_UNLOAD_HYST;
            low_limit            <= RST_LOW_LIMIT;
            driver_strength_code_o <= RST_STRENGTH;
            method               <= RST_METHOD;
            initial_driver_value <= RST_INIT_DRIVER;
            max_dropout          <= RST_MAX_DROPOUT;
            wait_code            <= RST_WAIT_REG_EN;
            post_code            <= RST_POST_RX_EN;
        end else if (do_write) begin
            if (w_strb[0]) begin
                case (aw_idx)
                    IDX_GUARD_TIME:     guard_time <= w_data[7:0];
                    IDX_MODE_ENABLES:   mode_enables <= w_data[7:0];
                    IDX_TARGET_CURRENT: target_current[7:0] <= w_data[7:0];
                    IDX_LOAD_HYST:      loading_hyst <= w_data[7:0];
                    IDX_UNLOAD_HYST:    unloading_hyst <= w_data[7:0];
                    IDX_LOW_LIMIT:      low_limit <= w_data[7:0];
                    IDX_DRV_STRENGTH:   driver_strength_code_o <= w_data[7:0];
                    IDX_LIMIT_METHOD:   method <= w_data[7:0];
                    IDX_INIT_DRIVER:    initial_driver_value <= w_data[7:0];
                    IDX_MAX_DROPOUT:    max_dropout[7:0] <= w_data[7:0];
                    IDX_WAIT_REG_EN:    wait_code <= w_data[7:0];
                    IDX_POST_RX_EN:     post_code <= w_data[7:0];
                    default: ;
                endcase
            end
            if (w_strb[1] && aw_idx == IDX_TARGET_CURRENT) begin
                target_current[15:8] <= w_data[15:8];
            end
            if (w_strb[1] && aw_idx == IDX_MAX_DROPOUT) begin
                max_dropout[15:8] <= w_data[15:8];
            end
        end
    end

    // Read channel
    always_comb begin
        rd_hit  = 1'b1;
        rd_word = '0;
        case (ar_idx)
            IDX_GUARD_TIME:     rd_word[7:0] = guard_time;
            IDX_MODE_ENABLES:   rd_word[7:0] = mode_enables;
            IDX_TARGET_CURRENT: rd_word[15:0] = target_current;
            IDX_LOAD_HYST:      rd_word[7:0] = loading_hyst;
            IDX_UNLOAD_HYST:    rd_word[7:0] = unloading_hyst;
            IDX_LOW_LIMIT:      rd_word[7:0] = low_limit;
            IDX_DRV_STRENGTH:   rd_word[7:0] = driver_strength_code_o;
            IDX_LIMIT_METHOD:   rd_word[7:0] = method;
            IDX_INIT_DRIVER:    rd_word[7:0] = initial_driver_value;
            IDX_MAX_DROPOUT:    rd_word[15:0] = max_dropout;
            IDX_WAIT_REG_EN:    rd_word[7:0] = wait_code;
            IDX_POST_RX_EN:     rd_word[7:0] = post_code;
            IDX_STATUS: begin
                rd_word[STAT_STATE_LSB +: 3] = state;
                rd_word[STAT_RES_LSB +: 16]  = driver_res_mohm_o;
            end
            default: rd_hit = 1'b0;
        endcase
    end

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            s_axi_rvalid_o <= 1'b0;
            s_axi_rdata_o  <= '0;
            s_axi_rresp_o  <= RESP_OKAY;
        end else if (s_axi_arvalid_i && s_axi_arready_o) begin
            s_axi_rvalid_o <= 1'b1;
            s_axi_rdata_o  <= rd_word;
            s_axi_rresp_o  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rready_i) begin
            s_axi_rvalid_o <= 1'b0;
        end
    end

    // Decoded settings; reserved codes and bits have no effect
    always_comb begin
        case (mode_i)
            MODE_READER:   mode_en = mode_enables[MODE_READER_BIT];
            MODE_ACT_INIT: mode_en = mode_enables[MODE_ACT_INIT_BIT];
            MODE_ACT_TGT:  mode_en = mode_enables[MODE_ACT_TGT_BIT];
            default:       mode_en = 1'b0;
        endcase
    end
    assign wait_en       = (wait_code == CODE_ENABLED);
    assign post_en       = (post_code == CODE_ENABLED);
    assign ron_control_o = (method == METHOD_RON);
    assign pwm_control_o = (method == METHOD_PWM);
    assign supply_low_limit_value_o = low_limit;

    // Driver resistance readback
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            driver_res_mohm_o <= RES_MIN_MOHM;
        end else if (driver_strength_code_o < STRENGTH_LIMIT) begin
            driver_res_mohm_o <= 16'(RES_NUM_MOHM / (int'(driver_strength_code_o) + 1));
        end else begin
            driver_res_mohm_o <= RES_MIN_MOHM;
        end
    end

    // Field-on: initial driver value and dropout check
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            driver_gate_setting_o <= '0;
            supply_safe_o         <= 1'b0;
            supply_stop_o         <= 1'b0;
        end else begin
            if (field_on_i) begin
                driver_gate_setting_o <= initial_driver_value;
            end
            supply_safe_o <= field_on_i && (dropout_mv_i > max_dropout) && !boost_bypass_i;
            supply_stop_o <= field_on_i && (dropout_mv_i > max_dropout) && boost_bypass_i;
        end
    end

    tpr_us_tick #(
        .CYCLES (GUARD_UNIT_CYC)
    ) u_tick (
        .clk_i     (clk_i),
        .sys_rst_i (sys_rst_i),
        .clr_i     (load_guard),
        .tick_o    (us_tick)
    );

    tpr_hyst_cmp u_cmp (
        .current_i     (measured_current_i),
        .target_i      (target_current),
        .reduction_i   (current_reduction_i),
        .load_hyst_i   (loading_hyst),
        .unload_hyst_i (unloading_hyst),
        .over_o        (over),
        .under_o       (under)
    );

    // Sequencer around transmit and receive
    always_comb begin
        next_state = state;
        load_guard = 1'b0;
        case (state)
            ST_IDLE: begin
                if (tx_request_i) begin
                    next_state = ST_PRE_REG;
                end else if (rx_stop_i && post_en) begin
                    next_state = ST_RX_GUARD;
                    load_guard = 1'b1;
                end
            end
            ST_PRE_REG: begin
                next_state = ST_TX_GUARD;
                load_guard = 1'b1;
            end
            ST_TX_GUARD: begin
                if (guard_cnt == 8'h00) begin
                    next_state = ST_IDLE;
                end
            end
            ST_RX_GUARD: begin
                if (guard_cnt == 8'h00) begin
                    next_state = ST_POST_REG;
                end
            end
            ST_POST_REG: next_state = ST_IDLE;
            default: next_state = ST_IDLE;
        endcase
    end

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            state <= ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            guard_cnt <= '0;
        end else if (load_guard) begin
            guard_cnt <= guard_time;
        end else if (us_tick && guard_cnt != 8'h00) begin
            guard_cnt <= guard_cnt - 8'h01;
        end
    end

    assign regulate_now = mode_en && ((state == ST_PRE_REG) || (state == ST_POST_REG)
                          || (state == ST_IDLE && in_wait_interval_i && wait_en && us_tick));
    assign regulating_o = (state != ST_IDLE);

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            supply_down_o <= 1'b0;
            supply_up_o   <= 1'b0;
            tx_start_o    <= 1'b0;
        end else begin
            supply_down_o <= regulate_now && over;
            supply_up_o   <= regulate_now && under;
            tx_start_o    <= (state == ST_TX_GUARD) && (guard_cnt == 8'h00);
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);

    property p_down_cause;
        supply_down_o |-> $past(regulate_now && over);
    endproperty
    a_down_cause: assert property (p_down_cause) else $error("supply down without cause");

    property p_up_cause;
        supply_up_o |-> $past(regulate_now && under);
    endproperty
    a_up_cause: assert property (p_up_cause) else $error("supply up without cause");

    property p_mode_gate;
        (supply_down_o || supply_up_o) |-> $past(mode_en);
    endproperty
    a_mode_gate: assert property (p_mode_gate) else $error("regulated in disabled mode");

    property p_pre_pass;
        (state == ST_IDLE && tx_request_i) |=> state == ST_PRE_REG ##1 state == ST_TX_GUARD;
    endproperty
    a_pre_pass: assert property (p_pre_pass) else $error("no pass before transmit");

    property p_tx_guard;
        tx_start_o |-> $past(state == ST_TX_GUARD && guard_cnt == 8'h00);
    endproperty
    a_tx_guard: assert property (p_tx_guard) else $error("transmit before guard end");

    property p_rx_guard;
        (state == ST_RX_GUARD && guard_cnt == 8'h00) |=> state == ST_POST_REG ##1 state == ST_IDLE;
    endproperty
    a_rx_guard: assert property (p_rx_guard) else $error("post pass sequence broken");

    property p_post_disabled;
        (state == ST_IDLE && !tx_request_i && rx_stop_i && !post_en) |=> state == ST_IDLE;
    endproperty
    a_post_disabled: assert property (p_post_disabled) else $error("post pass while disabled");

    property p_wait_disabled;
        (supply_down_o || supply_up_o) && $past(state == ST_IDLE) |-> $past(wait_en);
    endproperty
    a_wait_disabled: assert property (p_wait_disabled) else $error("wait regulation disabled");

    property p_gate_load;
        field_on_i |=> driver_gate_setting_o == $past(initial_driver_value);
    endproperty
    a_gate_load: assert property (p_gate_load) else $error("initial driver not applied");

    property p_dropout;
        (field_on_i && dropout_mv_i > max_dropout) |=> (supply_safe_o != supply_stop_o);
    endproperty
    a_dropout: assert property (p_dropout) else $error("dropout action missing");

endmodule
`default_nettype wire

// File: tpr_load_model.sv
`timescale 1ns/1ps
`default_nettype none
module tpr_load_model #(
    parameter logic [15:0] STEP_MA = 16'h0005
) (
    input  wire logic        clk_i,
    input  wire logic        sys_rst_i,
    input  wire logic        set_i,
    input  wire logic [15:0] load_ma_i,
    input  wire logic        down_i,
    input  wire logic        up_i,
    output logic [15:0]      current_o
);
    // Stage current follows supply steps
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            current_o <= 16'h0000;
        end else if (set_i) begin
            current_o <= load_ma_i;
        end else if (down_i) begin
            current_o <= current_o - STEP_MA;
        end else if (up_i) begin
            current_o <= current_o + STEP_MA;
        end
    end
endmodule
`default_nettype wire

// File: test_tpr_regulation.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin error_cnt++; \
    $display("Error %0t: got %0h want %0h", $time, a, e); end end
module test_tpr_regulation;
    import tpr_pkg::*;
    logic clk_i = 0, sys_rst_i = 1, set_load = 0, boost_bypass_i = 0, field_on_i = 0;
    logic s_axi_awvalid_i = 0, s_axi_wvalid_i = 0, s_axi_bready_i = 0;
    logic s_axi_arvalid_i = 0, s_axi_rready_i = 0, tx_request_i = 0, rx_stop_i = 0;
    logic in_wait_interval_i = 0, s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o;
    logic s_axi_arready_o, s_axi_rvalid_o, supply_down_o, supply_up_o, supply_safe_o;
    logic supply_stop_o, tx_start_o, ron_control_o, pwm_control_o, regulating_o;
    logic [15:0] s_axi_awaddr_i = 0, s_axi_araddr_i = 0, dropout_mv_i = 0, load = 0;
    logic [15:0] measured_current_i, driver_res_mohm_o;
    logic [31:0] s_axi_wdata_i = 0, s_axi_rdata_o, d;
    logic [3:0]  s_axi_wstrb_i = 4'hf;
    logic [1:0]  mode_i = 0, s_axi_bresp_o, s_axi_rresp_o, r;
    logic [7:0]  current_reduction_i = 0, driver_gate_setting_o, dsc, llv;
    logic [5:0]  p;
    int n[6], b[6], c, error_cnt = 0, cmp_count = 0;
    logic [15:0] sr[4] = '{16'h2710, 16'h09c4, 16'h01f4, 16'h01f4};
    logic [7:0]  sn[4] = '{8'h00, 8'h03, 8'h13, 8'hff};
    logic [1:0]  me[4] = '{2'b00, 2'b10, 2'b01, 2'b00};
    tpr_regulation uut (.clk_i, .sys_rst_i, .s_axi_awaddr_i, .s_axi_awvalid_i,
        .s_axi_awready_o, .s_axi_wdata_i, .s_axi_wstrb_i, .s_axi_wvalid_i, .s_axi_wready_o,
        .s_axi_bresp_o, .s_axi_bvalid_o, .s_axi_bready_i, .s_axi_araddr_i,
        .s_axi_arvalid_i, .s_axi_arready_o, .s_axi_rdata_o, .s_axi_rresp_o,
        .s_axi_rvalid_o, .s_axi_rready_i, .mode_i, .measured_current_i,
        .current_reduction_i, .dropout_mv_i, .boost_bypass_i, .field_on_i, .tx_request_i,
        .rx_stop_i, .in_wait_interval_i, .supply_down_o, .supply_up_o, .supply_safe_o,
        .supply_stop_o, .tx_start_o, .regulating_o, .driver_strength_code_o(dsc),
        .driver_res_mohm_o, .driver_gate_setting_o, .supply_low_limit_value_o(llv),
        .ron_control_o, .pwm_control_o);
    tpr_load_model load_model (.clk_i, .sys_rst_i, .set_i(set_load), .load_ma_i(load),
        .down_i(supply_down_o), .up_i(supply_up_o), .current_o(measured_current_i));
    assign p = {regulating_o, tx_start_o, supply_stop_o, supply_safe_o, supply_up_o,
                supply_down_o};
    initial forever #5 clk_i = ~clk_i;
    always @(posedge clk_i) foreach (n[k]) n[k] += (p[k] === 1'b1);
    task automatic wr(input logic [13:0] i, input logic [31:0] v);
        @(posedge clk_i);
        s_axi_awaddr_i <= {i, 2'b00};
        s_axi_wdata_i <= v;
        s_axi_awvalid_i <= 1'b1;
        s_axi_wvalid_i <= 1'b1;
        s_axi_bready_i <= 1'b1;
        forever begin
            @(posedge clk_i);
            if (s_axi_awready_o) s_axi_awvalid_i <= 1'b0;
            if (s_axi_wready_o) s_axi_wvalid_i <= 1'b0;
            if (s_axi_bvalid_o) break;
        end
        r = s_axi_bresp_o;
        s_axi_bready_i <= 1'b0;
        repeat (2) @(posedge clk_i);
    endtask
    task automatic rd(input logic [13:0] i);
        @(posedge clk_i);
        s_axi_araddr_i <= {i, 2'b00};
        s_axi_arvalid_i <= 1'b1;
        s_axi_rready_i <= 1'b1;
        forever begin
            @(posedge clk_i);
            if (s_axi_arready_o) s_axi_arvalid_i <= 1'b0;
            if (s_axi_rvalid_o) break;
        end
        d = s_axi_rdata_o;
        r = s_axi_rresp_o;
        s_axi_rready_i <= 1'b0;
    endtask
    task automatic ev(input int sel, input logic [15:0] v);
        b = n;
        @(posedge clk_i);
        load <= v;
        set_load <= 1'b1;
        @(posedge clk_i);
        set_load <= 1'b0;
        tx_request_i <= (sel == 0);
        rx_stop_i <= (sel == 1);
        field_on_i <= (sel == 2);
        @(posedge clk_i);
        {tx_request_i, rx_stop_i, field_on_i} <= 3'b000;
        c = 0;
        while (n[4] == b[4] && n[1] == b[1] && c < 150) begin
            @(posedge clk_i);
            c++;
        end
    endtask
    task automatic wrap_up;
        if (error_cnt == 0 && cmp_count > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    initial begin
        repeat (6000) @(posedge clk_i);
        error_cnt++;
        wrap_up();
    end
    initial begin
        repeat (4) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        rd(IDX_MAX_DROPOUT);
        `CHK(d, 32'h00000e10)
        rd(14'h0001);
        `CHK(r, RESP_SLVERR)
        wr(14'h0001, 32'h0);
        `CHK(r, RESP_SLVERR)
        for (int k = 0; k < 4; k++) begin
            wr(IDX_DRV_STRENGTH, {24'h0, sn[k]});
            `CHK(driver_res_mohm_o, sr[k])
            `CHK(dsc, sn[k])
            wr(IDX_LIMIT_METHOD, k);
            `CHK({ron_control_o, pwm_control_o}, me[k])
        end
        wr(IDX_GUARD_TIME, 32'h1);
        `CHK(r, RESP_OKAY)
        wr(IDX_UNLOAD_HYST, 32'h0a);
        wr(IDX_LOW_LIMIT, 32'h5a);
        `CHK(llv, 8'h5a)
        for (int m = 0; m < 6; m++) begin
            mode_i <= m % 3;
            wr(IDX_MODE_ENABLES, (m < 3) ? (1 << m) : (7 ^ (1 << (m - 3))));
            ev(0, 16'h012c);
            `CHK(n[0] - b[0], (m < 3) ? 1 : 0)
            `CHK(c >= 100 && c <= 110, 1)
            `CHK(n[5] - b[5] > 100, 1)
        end
        wr(IDX_MODE_ENABLES, 32'h7);
        current_reduction_i <= 8'h1e;
        ev(0, 16'h00f0);
        `CHK(n[0] - b[0], 1)
        current_reduction_i <= 8'h00;
        ev(1, 16'h00e6);
        `CHK(c >= 100 && c <= 110, 1)
        repeat (150) @(posedge clk_i);
        `CHK(n[1] - b[1], 1)
        wr(IDX_POST_RX_EN, 32'h2);
        ev(1, 16'h00e6);
        repeat (150) @(posedge clk_i);
        `CHK(n[1] - b[1], 0)
        in_wait_interval_i <= 1'b1;
        ev(1, 16'h00e6);
        `CHK(n[1] - b[1], 1)
        wr(IDX_WAIT_REG_EN, 32'h0);
        ev(1, 16'h00e6);
        `CHK(n[1] - b[1], 0)
        in_wait_interval_i <= 1'b0;
        wr(IDX_INIT_DRIVER, 32'h3c);
        for (int f = 0; f < 3; f++) begin
            dropout_mv_i <= (f == 2) ? 16'h0bb8 : 16'h0fa0;
            boost_bypass_i <= (f == 1);
            ev(2, 16'h00fa);
            `CHK({n[3] - b[3], n[2] - b[2]}, {f == 1 ? 1 : 0, f == 0 ? 1 : 0})
            `CHK(driver_gate_setting_o, 8'h3c)
        end
        rd(IDX_STATUS);
        `CHK(d, 32'h01f40000)
        wr(IDX_TARGET_CURRENT, 32'hffff0123);
        rd(IDX_TARGET_CURRENT);
        `CHK(d, 32'h00000123)
        wrap_up();
    end
endmodule
`default_nettype wire
